// file: rtl/fpl_pkg.sv
// package of constants and types for the front panel indicator controller
`default_nettype none
package fpl_pkg;
  // clock rate and derived blink timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned BLINK_PERIOD_MS = 1000;
  localparam int unsigned HALF_BLINK_CYC = (CLK_HZ / 1000) * BLINK_PERIOD_MS / 2;
  localparam int unsigned ID_TIMED_S = 15;
  localparam int unsigned ID_TIMED_HALVES = ID_TIMED_S * 2;
  localparam logic [25:0] BLINK_CNT_RST = 26'h0000000;
  localparam logic [5:0] ID_CNT_RST = 6'h00;
  // power state encoding of the platform state input
  typedef enum logic [2:0] {
    FPL_PWR_OFF_LEGACY = 3'h0,
    FPL_PWR_ON_LEGACY  = 3'h1,
    FPL_PWR_S5         = 3'h2,
    FPL_PWR_S4         = 3'h3,
    FPL_PWR_SLEEP      = 3'h4,
    FPL_PWR_S0         = 3'h5
  } fpl_pwr_type;
  // identify command values
  typedef enum logic [1:0] {
    FPL_ID_CMD_OFF     = 2'h0,
    FPL_ID_CMD_TIMED   = 2'h1,
    FPL_ID_CMD_FOREVER = 2'h2
  } fpl_idcmd_type;
  // identify mode, one-hot
  typedef enum logic [3:0] {
    FPL_IDM_OFF     = 4'h1,
    FPL_IDM_STEADY  = 4'h2,
    FPL_IDM_TIMED   = 4'h4,
    FPL_IDM_FOREVER = 4'h8
  } fpl_idm_type;
endpackage : fpl_pkg
`default_nettype wire

// file: rtl/fpl_front_panel.sv
// front panel indicator controller: power, status, identify and disk leds
//
// Function
// R1 - legacy power off: power led dark
// R2 - legacy power on before firmware init: power led steady on
// R3 - soft-off and hibernate: power led dark
// R4 - sleep states S3 to S1: power led blinks slowly
// R5 - working state S0: power led steady on
// R6 - every blink about 1 Hz, half on, half off
// R7 - during controller start-up status led alternates amber and green
// R8 - panel buttons ignored until controller start-up complete
// R9 - start-up done ends alternating blink, power button works again
// R10 - booted, ready, no fault: status led solid green
// R11 - degraded condition: status led blinks green
// R12 - non-critical alarm: status led blinks amber
// R13 - fatal condition: status led solid amber
// R14 - any amber indication forces green element off
// R15 - each identify button press toggles blue led steady on/off
// R16 - identify command: blink 15 s then off, or blink until off command
// R17 - disk led driven by onboard controllers plus add-in activity input
// R18 - most severe fault shown: fatal, non-critical, degraded, normal
// R19 - onboard and add-in disk activity combined by logical or
`default_nettype none
module fpl_front_panel #(
  // half blink period in cycles; the 26-bit divider limits it to 2**26
  parameter int unsigned BLINK_HALF_CYC = fpl_pkg::HALF_BLINK_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [2:0] power_state,
  input wire logic standby_supply_present,
  input wire logic board_management_controller_init_done,
  input wire logic system_ready,
  input wire logic fault_degraded,
  input wire logic fault_noncritical,
  input wire logic fault_fatal,
  input wire logic power_button_n,
  input wire logic identify_button_n,
  input wire logic id_cmd_valid,
  input wire logic [1:0] id_cmd_value,
  input wire logic disk_act_onboard,
  input wire logic disk_act_addin,
  output logic power_led,
  output logic status_green_led,
  output logic status_amber_led,
  output logic identify_led,
  output logic disk_act_led,
  output logic power_button_req,
  output logic buttons_enabled
);

  // ******************************************************
  // state
  // ******************************************************
  typedef struct packed {
    logic [1:0] pwr_btn_sync;
    logic [1:0] id_btn_sync;
    logic [1:0] init_sync;
    logic [1:0] stby_sync;
    logic [1:0] disk_sync;
    logic pwr_btn_prev;
    logic id_btn_prev;
    logic [25:0] blink_cnt;
    logic blink_phase;
    logic [5:0] id_cnt;
    fpl_pkg::fpl_idm_type id_mode;
    logic power_led;
    logic green;
    logic amber;
    logic id_led;
    logic disk_led;
    logic pwr_req;
  } fpl_state_type;

  fpl_state_type st_r;
  fpl_state_type st_nxt;

  // ******************************************************
  // helpers
  // ******************************************************
  // true when a button has just gone from released to pressed
  function automatic logic press_edge(input logic now_n, input logic prev_n);
    press_edge = prev_n & ~now_n;
  endfunction : press_edge

  logic half_tick;
  logic init_done_s;
  logic stby_s;
  logic pwr_press;
  logic id_press;

  always_comb begin
    // terminal count of the shared divider
    half_tick = (st_r.blink_cnt == 26'(BLINK_HALF_CYC - 1));
    init_done_s = st_r.init_sync[1];
    stby_s = st_r.stby_sync[1];
    pwr_press = press_edge(st_r.pwr_btn_sync[1], st_r.pwr_btn_prev) & init_done_s; // R8 R9
    id_press = press_edge(st_r.id_btn_sync[1], st_r.id_btn_prev) & init_done_s; // R8
  end

  // ******************************************************
  // next state
  // ******************************************************
  // one combinational pass fills every field; led outputs are registered
  always_comb begin
    st_nxt = st_r;
    // two-flop synchronisers for pins from outside this clock domain
    st_nxt.pwr_btn_sync = {st_r.pwr_btn_sync[0], power_button_n};
    st_nxt.id_btn_sync = {st_r.id_btn_sync[0], identify_button_n};
    st_nxt.init_sync = {st_r.init_sync[0], board_management_controller_init_done};
    st_nxt.stby_sync = {st_r.stby_sync[0], standby_supply_present};
    st_nxt.disk_sync = {st_r.disk_sync[0], disk_act_onboard | disk_act_addin}; // R19
    st_nxt.pwr_btn_prev = st_r.pwr_btn_sync[1];
    st_nxt.id_btn_prev = st_r.id_btn_sync[1];

    // shared half-period divider, so all blinks run in step at ~1 Hz
    if (half_tick) begin
      st_nxt.blink_cnt = fpl_pkg::BLINK_CNT_RST;
      st_nxt.blink_phase = ~st_r.blink_phase; // R6
    end else begin
      st_nxt.blink_cnt = st_r.blink_cnt + 26'h0000001;
    end

    // power led from the platform power state
    case (power_state)
      3'(fpl_pkg::FPL_PWR_OFF_LEGACY): st_nxt.power_led = 1'b0; // R1
      3'(fpl_pkg::FPL_PWR_ON_LEGACY): st_nxt.power_led = 1'b1; // R2
      3'(fpl_pkg::FPL_PWR_S5): st_nxt.power_led = 1'b0; // R3
      3'(fpl_pkg::FPL_PWR_S4): st_nxt.power_led = 1'b0; // R3
      3'(fpl_pkg::FPL_PWR_SLEEP): st_nxt.power_led = st_r.blink_phase; // R4
      3'(fpl_pkg::FPL_PWR_S0): st_nxt.power_led = 1'b1; // R5
      default: st_nxt.power_led = 1'b0;
    endcase

    // status led: start-up blink first, then severity ranking, amber wins
    if (!stby_s) begin
      st_nxt.green = 1'b0;
      st_nxt.amber = 1'b0;
    end else if (!init_done_s) begin
      st_nxt.green = st_r.blink_phase; // R7
      st_nxt.amber = ~st_r.blink_phase; // R7
    end else if (fault_fatal) begin
      st_nxt.green = 1'b0; // R14 R18
      st_nxt.amber = 1'b1; // R13
    end else if (fault_noncritical) begin
      st_nxt.green = 1'b0; // R14 R18
      st_nxt.amber = st_r.blink_phase; // R12
    end else if (fault_degraded) begin
      st_nxt.green = st_r.blink_phase; // R11 R18
      st_nxt.amber = 1'b0;
    end else begin
      st_nxt.green = system_ready; // R10
      st_nxt.amber = 1'b0;
    end

    // identify mode; a command overrides a simultaneous button press
    if (id_cmd_valid) begin
      st_nxt.id_cnt = fpl_pkg::ID_CNT_RST;
      case (id_cmd_value)
        fpl_pkg::FPL_ID_CMD_TIMED: st_nxt.id_mode = fpl_pkg::FPL_IDM_TIMED; // R16
        fpl_pkg::FPL_ID_CMD_FOREVER: st_nxt.id_mode = fpl_pkg::FPL_IDM_FOREVER; // R16
        default: st_nxt.id_mode = fpl_pkg::FPL_IDM_OFF; // R16
      endcase
    end else if (id_press) begin
      st_nxt.id_mode = (st_r.id_mode == fpl_pkg::FPL_IDM_STEADY) ? fpl_pkg::FPL_IDM_OFF
                                                                : fpl_pkg::FPL_IDM_STEADY; // R15
    end else if (st_r.id_mode == fpl_pkg::FPL_IDM_TIMED && half_tick) begin
      if (st_r.id_cnt == 6'(fpl_pkg::ID_TIMED_HALVES - 1)) begin
        st_nxt.id_mode = fpl_pkg::FPL_IDM_OFF; // R16
      end else begin
        st_nxt.id_cnt = st_r.id_cnt + 6'h01;
      end
    end

    case (st_r.id_mode)
      fpl_pkg::FPL_IDM_OFF: st_nxt.id_led = 1'b0;
      fpl_pkg::FPL_IDM_STEADY: st_nxt.id_led = 1'b1; // R15
      fpl_pkg::FPL_IDM_TIMED: st_nxt.id_led = st_r.blink_phase; // R16
      fpl_pkg::FPL_IDM_FOREVER: st_nxt.id_led = st_r.blink_phase; // R16
      default: st_nxt.id_led = 1'b0;
    endcase

    st_nxt.disk_led = st_r.disk_sync[1]; // R17
    st_nxt.pwr_req = pwr_press; // R9
  end

  // ******************************************************
  // registers
  // ******************************************************
  // synchronous reset; buttons idle high so their syncs reset to released
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.pwr_btn_sync <= 2'h3;
      st_r.id_btn_sync <= 2'h3;
      st_r.pwr_btn_prev <= 1'b1;
      st_r.id_btn_prev <= 1'b1;
      st_r.id_mode <= fpl_pkg::FPL_IDM_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ******************************************************
  // outputs
  // ******************************************************
  // all data outputs are straight from flip-flops
  always_comb begin
    power_led = st_r.power_led;
    status_green_led = st_r.green;
    status_amber_led = st_r.amber;
    identify_led = st_r.id_led;
    disk_act_led = st_r.disk_led;
    power_button_req = st_r.pwr_req;
    buttons_enabled = init_done_s; // R8
  end

  // ******************************************************
  // assertions
  // ******************************************************
  sequence s_locked;
    !st_r.init_sync[1];
  endsequence

  a_buttons_locked: assert property (@(posedge core_clk) disable iff (rst) // R8
    s_locked |=> !power_button_req) else $error("power press passed during start-up");

  a_amber_beats_green: assert property (@(posedge core_clk) disable iff (rst) // R14
    status_amber_led |-> !status_green_led) else $error("green lit with amber");

  a_fatal_solid: assert property (@(posedge core_clk) disable iff (rst) // R13
    (st_r.stby_sync[1] && st_r.init_sync[1] && fault_fatal) |=> status_amber_led)
    else $error("fatal not solid amber");

  a_s0_steady: assert property (@(posedge core_clk) disable iff (rst) // R5
    (power_state == 3'(fpl_pkg::FPL_PWR_S0)) |=> power_led) else $error("power led not on in S0");

  a_soft_off_dark: assert property (@(posedge core_clk) disable iff (rst) // R3
    (power_state == 3'(fpl_pkg::FPL_PWR_S5) || power_state == 3'(fpl_pkg::FPL_PWR_S4)) |=> !power_led)
    else $error("power led lit in soft off");

  a_legacy_off: assert property (@(posedge core_clk) disable iff (rst) // R1
    (power_state == 3'(fpl_pkg::FPL_PWR_OFF_LEGACY)) |=> !power_led) else $error("power led lit when off");

  a_blink_period: assert property (@(posedge core_clk) disable iff (rst) // R6
    half_tick |=> !half_tick [*8]) else $error("blink divider too fast");

  a_startup_alt: assert property (@(posedge core_clk) disable iff (rst) // R7
    (st_r.stby_sync[1] && !st_r.init_sync[1]) |=> (status_green_led != status_amber_led))
    else $error("start-up blink not alternating");

  a_disk_or: assert property (@(posedge core_clk) disable iff (rst) // R19
    (disk_act_onboard || disk_act_addin) |-> ##3 disk_act_led) else $error("disk activity lost");

  a_id_cmd_off: assert property (@(posedge core_clk) disable iff (rst) // R16
    (id_cmd_valid && id_cmd_value == fpl_pkg::FPL_ID_CMD_OFF) |-> ##2 !identify_led)
    else $error("identify not off after off command");

  // power state asks for the slow blink
  sequence s_asleep;
    power_state == 3'(fpl_pkg::FPL_PWR_SLEEP);
  endsequence

  // standby present and controller up, so the severity ranking decides
  sequence s_booted;
    st_r.stby_sync[1] && st_r.init_sync[1];
  endsequence

  // last half period of a timed identify with nothing overriding it
  sequence s_timed_last;
    (st_r.id_mode == fpl_pkg::FPL_IDM_TIMED) && half_tick && !id_cmd_valid && !id_press &&
      (st_r.id_cnt == 6'(fpl_pkg::ID_TIMED_HALVES - 1));
  endsequence

  // mode drops to off, then the led goes dark one cycle later
  sequence s_id_goes_dark;
    (st_r.id_mode == fpl_pkg::FPL_IDM_OFF) ##1 !identify_led;
  endsequence

  a_legacy_on: assert property (@(posedge core_clk) disable iff (rst) // R2
    (power_state == 3'(fpl_pkg::FPL_PWR_ON_LEGACY)) |=> power_led) else $error("power led dark in legacy on");

  a_sleep_blink: assert property (@(posedge core_clk) disable iff (rst) // R4
    s_asleep |=> (power_led == $past(st_r.blink_phase))) else $error("sleep led off the blink phase");

  a_ready_green: assert property (@(posedge core_clk) disable iff (rst) // R10
    s_booted ##0 (!fault_fatal && !fault_noncritical && !fault_degraded && system_ready)
    |=> (status_green_led && !status_amber_led)) else $error("ready but status not solid green");

  a_degraded_blink: assert property (@(posedge core_clk) disable iff (rst) // R11
    s_booted ##0 (!fault_fatal && !fault_noncritical && fault_degraded)
    |=> (!status_amber_led && status_green_led == $past(st_r.blink_phase))) else $error("degraded not green blink");

  a_noncrit_blink: assert property (@(posedge core_clk) disable iff (rst) // R12
    s_booted ##0 (!fault_fatal && fault_noncritical)
    |=> (!status_green_led && status_amber_led == $past(st_r.blink_phase))) else $error("alarm not amber blink");

  a_id_steady: assert property (@(posedge core_clk) disable iff (rst) // R15
    (st_r.id_mode == fpl_pkg::FPL_IDM_STEADY) |=> identify_led) else $error("steady identify not lit");

  a_timed_ends: assert property (@(posedge core_clk) disable iff (rst) // R16
    s_timed_last |=> s_id_goes_dark) else $error("timed identify did not end");

  a_press_req: assert property (@(posedge core_clk) disable iff (rst) // R9
    (st_r.init_sync[1] && st_r.pwr_btn_prev && !st_r.pwr_btn_sync[1]) |=> power_button_req)
    else $error("accepted press gave no request");

  // one request per press, so a held button cannot repeat
  a_req_pulse: assert property (@(posedge core_clk) disable iff (rst) // R9
    power_button_req |=> !power_button_req) else $error("power request longer than one cycle");

endmodule : fpl_front_panel
`default_nettype wire

// file: verif/fpl_panel_model.sv
// behavioural model of the panel push buttons that face the controller
`default_nettype none
module fpl_panel_model (
  input wire logic press_power,
  input wire logic press_identify,
  output logic power_button_n,
  output logic identify_button_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // contacts pull the line low while pressed; pull-ups give a high idle level
  assign power_button_n = ~press_power;
  assign identify_button_n = ~press_identify;
endmodule : fpl_panel_model
`default_nettype wire

// file: verif/fpl_front_panel_tb.sv
// self-checking bench for the front panel indicator controller
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module fpl_front_panel_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // signals
  // ****************
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] power_state = 3'h0;
  logic standby_supply_present = 1'b1;
  logic board_management_controller_init_done = 1'b0;
  logic system_ready = 1'b0;
  logic fault_degraded = 1'b0;
  logic fault_noncritical = 1'b0;
  logic fault_fatal = 1'b0;
  logic press_power = 1'b0;
  logic press_identify = 1'b0;
  logic id_cmd_valid = 1'b0;
  logic [1:0] id_cmd_value = 2'h0;
  logic disk_act_onboard = 1'b0;
  logic disk_act_addin = 1'b0;
  wire logic power_button_n, identify_button_n, power_led, status_green_led, status_amber_led;
  wire logic identify_led, disk_act_led, power_button_req, buttons_enabled;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_req = 0;
  int r0;
  // short blink half period so whole blinks and a timed identify fit in one run
  localparam int TB_HALF = 16;
  initial forever #10 core_clk = ~core_clk;
  // requests counted at the falling edge, where the registered pulse is settled
  always @(negedge core_clk) if (power_button_req === 1'b1) n_req++;
  fpl_panel_model i_panel (.press_power(press_power), .press_identify(press_identify),
    .power_button_n(power_button_n), .identify_button_n(identify_button_n));
  fpl_front_panel #(.BLINK_HALF_CYC(TB_HALF)) i_dut (.core_clk(core_clk), .rst(rst), .power_state(power_state),
    .standby_supply_present(standby_supply_present),
    .board_management_controller_init_done(board_management_controller_init_done),
    .system_ready(system_ready), .fault_degraded(fault_degraded), .fault_noncritical(fault_noncritical),
    .fault_fatal(fault_fatal), .power_button_n(power_button_n), .identify_button_n(identify_button_n),
    .id_cmd_valid(id_cmd_valid), .id_cmd_value(id_cmd_value), .disk_act_onboard(disk_act_onboard),
    .disk_act_addin(disk_act_addin), .power_led(power_led), .status_green_led(status_green_led),
    .status_amber_led(status_amber_led), .identify_led(identify_led), .disk_act_led(disk_act_led),
    .power_button_req(power_button_req), .buttons_enabled(buttons_enabled));
  // ****************
  // helpers
  // ****************
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  // press held 4 cycles so it survives the two-flop sync, then settle
  task automatic push(input logic pwr);
    @(posedge core_clk);
    press_power <= pwr;
    press_identify <= ~pwr;
    repeat (4) @(posedge core_clk);
    press_power <= 1'b0;
    press_identify <= 1'b0;
    tick(8);
  endtask : push
  task automatic idcmd(input logic [1:0] v);
    @(posedge core_clk);
    id_cmd_valid <= 1'b1;
    id_cmd_value <= v;
    @(posedge core_clk);
    id_cmd_valid <= 1'b0;
    tick(4);
  endtask : idcmd
  // ****************
  // scenarios
  // ****************
  task automatic t_startup();
    @(posedge core_clk);
    system_ready <= 1'b1;
    tick(4);
    `CHK(buttons_enabled, 1'b0)
    `CHK(status_green_led ^ status_amber_led, 1'b1)
    r0 = n_req;
    push(1'b1);
    push(1'b0);
    `CHK(n_req - r0, 0)
    `CHK(identify_led, 1'b0)
    $display("test startup done");
  endtask : t_startup
  task automatic t_power();
    logic [2:0] st [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
    logic ex [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      power_state <= st[i];
      tick(3);
      `CHK(power_led, ex[i])
    end
    $display("test power done");
  endtask : t_power
  task automatic t_ready();
    @(posedge core_clk);
    board_management_controller_init_done <= 1'b1;
    tick(4);
    `CHK(buttons_enabled, 1'b1)
    `CHK({status_green_led, status_amber_led}, 2'h2)
    r0 = n_req;
    push(1'b1);
    `CHK(n_req - r0, 1)
    push(1'b0);
    `CHK(identify_led, 1'b1)
    push(1'b0);
    `CHK(identify_led, 1'b0)
    $display("test ready done");
  endtask : t_ready
  task automatic t_sev();
    @(posedge core_clk);
    {fault_degraded, fault_noncritical, fault_fatal} <= 3'h7;
    tick(3);
    `CHK({status_green_led, status_amber_led}, 2'h1)
    @(posedge core_clk);
    fault_fatal <= 1'b0;
    tick(3);
    `CHK(status_green_led, 1'b0)
    @(posedge core_clk);
    fault_noncritical <= 1'b0;
    power_state <= fpl_pkg::FPL_PWR_SLEEP;
    tick(3);
    `CHK(status_amber_led, 1'b0)
    `CHK(power_led, status_green_led)
    idcmd(fpl_pkg::FPL_ID_CMD_FOREVER);
    `CHK(identify_led, status_green_led)
    idcmd(fpl_pkg::FPL_ID_CMD_OFF);
    `CHK(identify_led, 1'b0)
    idcmd(fpl_pkg::FPL_ID_CMD_TIMED);
    `CHK(identify_led, status_green_led)
    idcmd(2'h3);
    `CHK(identify_led, 1'b0)
    $display("test severity done");
  endtask : t_sev
  task automatic t_disk();
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      {disk_act_onboard, disk_act_addin} <= i[1:0];
      tick(4);
      `CHK(disk_act_led, |i[1:0])
    end
    $display("test disk done");
  endtask : t_disk
  // sleep blink: on and off runs of one half period each
  task automatic t_blink();
    int run_len = 0;
    int n_runs = 0;
    logic last;
    @(posedge core_clk);
    power_state <= fpl_pkg::FPL_PWR_SLEEP;
    tick(3);
    last = power_led;
    for (int i = 0; i < 5 * TB_HALF; i++) begin
      tick(1);
      run_len++;
      if (power_led !== last) begin
        if (n_runs > 0) `CHK(run_len, TB_HALF)
        n_runs++;
        run_len = 0;
        last = power_led;
      end
    end
    `CHK(n_runs > 2, 1'b1)
    $display("test blink done");
  endtask : t_blink
  // timed identify: still blinking late in its 30 half periods, dark after them
  task automatic t_id_timed();
    int seen_hi = 0;
    int seen_lo = 0;
    int lit_late = 0;
    idcmd(fpl_pkg::FPL_ID_CMD_TIMED);
    tick(26 * TB_HALF - 4);
    for (int i = 0; i < 2 * TB_HALF; i++) begin
      tick(1);
      if (identify_led === 1'b1) seen_hi++;
      if (identify_led === 1'b0) seen_lo++;
    end
    tick(3 * TB_HALF);
    for (int i = 0; i < 2 * TB_HALF; i++) begin
      tick(1);
      if (identify_led !== 1'b0) lit_late++;
    end
    `CHK((seen_hi > 0) && (seen_lo > 0), 1'b1)
    `CHK(lit_late, 0)
    $display("test identify timed done");
  endtask : t_id_timed
  // mid-run reset: buttons locked until the controller flag passes its sync again
  task automatic t_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    tick(2);
    `CHK({buttons_enabled, power_button_req}, 2'h0)
    @(posedge core_clk);
    rst <= 1'b0;
    tick(1);
    `CHK(buttons_enabled, 1'b0)
    tick(3);
    `CHK(buttons_enabled, 1'b1)
    $display("test reset done");
  endtask : t_reset
  // ****************
  // run control
  // ****************
  task automatic wrap_up();
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  // whole run is under 800 cycles; 100 us leaves ample margin
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_startup();
    t_power();
    t_ready();
    t_sev();
    t_blink();
    t_id_timed();
    t_disk();
    t_reset();
    wrap_up();
  end
endmodule : fpl_front_panel_tb
`undef CHK
`default_nettype wire
